// [verilog/dccr_pkg.sv]
// dccr_pkg: register map, field positions and reset values of the carrier correction slice
// assumes byte-wide registers on a plain strobe port with 8-bit address
package dccr_pkg;
	localparam logic [7:0] ADDR_HB_CONTROL = 8'h1e;
	localparam logic [7:0] ADDR_CHIP_IDENTITY = 8'h1f;
	localparam logic [7:0] ADDR_TUNING_BYTE0 = 8'h30;
	localparam logic [7:0] ADDR_TUNING_BYTE1 = 8'h31;
	localparam logic [7:0] ADDR_TUNING_BYTE2 = 8'h32;
	localparam logic [7:0] ADDR_TUNING_BYTE3 = 8'h33;
	localparam logic [7:0] ADDR_PHASE_LOW = 8'h34;
	localparam logic [7:0] ADDR_PHASE_HIGH = 8'h35;
	localparam logic [7:0] ADDR_UPDATE = 8'h36;
	localparam logic [7:0] ADDR_I_SKEW_LOW = 8'h38;
	localparam logic [7:0] ADDR_I_SKEW_HIGH = 8'h39;
	localparam logic [7:0] ADDR_Q_SKEW_LOW = 8'h3a;
	localparam logic [7:0] ADDR_Q_SKEW_HIGH = 8'h3b;
	localparam logic [7:0] ADDR_I_DC_LOW = 8'h3c;
	localparam logic [7:0] ADDR_I_DC_HIGH = 8'h3d;
	localparam logic [7:0] ADDR_Q_DC_LOW = 8'h3e;
	localparam logic [7:0] ADDR_Q_DC_HIGH = 8'h3f;
	localparam logic [7:0] ADDR_I_FULLSCALE_LOW = 8'h40;
	localparam logic [7:0] ADDR_I_CONTROL = 8'h41;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h50;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h51;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h52;

	localparam int BIT_STAGE3_BYPASS = 0;
	localparam int BIT_APPLY_REQUEST = 0;
	localparam int BIT_APPLY_DONE = 1;
	localparam int BIT_FRAME_REQUEST = 4;
	localparam int BIT_FRAME_DONE = 5;
	localparam int BIT_I_SLEEP = 7;
	localparam int BIT_IRQ_APPLY = 0;
	localparam int BIT_IRQ_FRAME = 1;

	localparam logic [7:0] RESET_ZERO = 8'h00;
	localparam logic [7:0] RESET_I_FULLSCALE_LOW = 8'hf9;
	localparam logic [7:0] RESET_I_CONTROL = 8'h01;
	localparam logic [7:0] IDENTITY_DEFAULT = 8'h5a; // arbitrary value
	localparam logic [1:0] IRQ_NONE = 2'h0;
	localparam logic [7:0] SKEW_HIGH_MASK = 8'h03;
	localparam logic [7:0] CONTROL_MASK = 8'h83;
	localparam logic [7:0] UPDATE_WR_MASK = 8'h11;

	typedef enum logic [1:0] {DCCR_FRAME_IDLE, DCCR_FRAME_ARMED, DCCR_FRAME_DONE} dccr_frame_t;
endpackage

// [verilog/dccr_sample_adjust.sv]
// dccr_sample_adjust: adds a dc shift to one channel's sample, with saturation
// assumes samples and shift are two's complement on the same clock
`timescale 1ns/1ps
module dccr_sample_adjust #(
	parameter int WIDTH = 16
) (
	input wire logic ref_clk, // data clock
	input wire logic reset, // async, active high
	input wire logic clk_en, // freezes state when low
	input wire logic [WIDTH-1:0] sample_in, // raw sample
	input wire logic [WIDTH-1:0] dc_shift, // offset to add
	output logic [WIDTH-1:0] sample_out // registered sum
);
	logic [WIDTH:0] sum;
	logic [WIDTH-1:0] next_sample;

	// saturate rather than wrap: a wrap would flip full-scale polarity
	always_comb begin
		sum = {sample_in[WIDTH-1], sample_in} + {dc_shift[WIDTH-1], dc_shift};
		if (sum[WIDTH] != sum[WIDTH-1]) begin
			next_sample = {sum[WIDTH], {(WIDTH-1){~sum[WIDTH]}}};
		end else begin
			next_sample = sum[WIDTH-1:0];
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sample_out <= '0;
		end else if (clk_en) begin
			sample_out <= next_sample;
		end
	end
endmodule

// [verilog/dccr_regs.sv]
// dccr_regs: carrier correction register slice of a dual-channel converter datapath
// assumes byte strobe port on ref_clk; frame pin is asynchronous and is synchronised here
//
// Function
// - A set third-stage bypass bit routes data around the third half-band stage.
// - Address 0x1f reads a fixed eight-bit identification value and ignores writes.
// - The 32-bit tuning word sits in four bytes, low byte at 0x30, high byte at 0x33.
// - Writing the tuning bytes leaves the oscillator frequency unchanged.
// - A zero-to-one change of bit 0 at 0x36 loads the pending tuning word.
// - Once the word is loaded, bit 1 of 0x36 reads one.
// - With bit 4 of 0x36 set, the next extended frame pulse resets the oscillator.
// - After that frame reset, bit 5 of 0x36 reads one.
// - On oscillator reset the phase starts at the signed 16-bit offset of 0x34/0x35.
// - Ten-bit skew per channel from 0x38/0x39 and 0x3a/0x3b goes to the datapath.
// - A 16-bit dc shift per channel from 0x3c..0x3f is added to every sample.
// - Bit 7 of 0x41 puts the in-phase converter to sleep.
// - The in-phase full-scale code is 0x40 low byte with bits 1:0 of 0x41 above.
`timescale 1ns/1ps
module dccr_regs #(
	parameter int SAMPLE_WIDTH = 16,
	parameter int FRAME_EXT_CYCLES = 2,
	parameter logic [7:0] CHIP_IDENTITY = dccr_pkg::IDENTITY_DEFAULT // arbitrary value
) (
	input wire logic ref_clk, // data clock
	input wire logic reset, // async, active high
	input wire logic clk_en, // freezes all state when low
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_write, // write strobe
	input wire logic reg_read, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic frame_pin, // asynchronous frame pulse
	input wire logic [SAMPLE_WIDTH-1:0] inphase_sample, // in-phase sample
	input wire logic [SAMPLE_WIDTH-1:0] quadrature_sample, // quadrature sample
	output logic [SAMPLE_WIDTH-1:0] inphase_out, // shifted in-phase sample
	output logic [SAMPLE_WIDTH-1:0] quadrature_out, // shifted quadrature sample
	output logic third_halfband_bypass, // bypass third half-band stage
	output logic [31:0] carrier_tuning_word, // active tuning word
	output logic carrier_phase_load, // one-cycle oscillator reset pulse
	output logic [15:0] carrier_phase_start, // phase loaded at oscillator reset
	output logic [9:0] inphase_skew, // in-phase phase adjust
	output logic [9:0] quadrature_skew, // quadrature phase adjust
	output logic inphase_sleep, // in-phase converter sleep
	output logic [9:0] inphase_fullscale_code, // in-phase full-scale code
	output logic irq // level interrupt
);
	logic [7:0] hb_control;
	logic [7:0] tuning_pending [4];
	logic [7:0] phase_low;
	logic [7:0] phase_high;
	logic [7:0] i_skew_low;
	logic [7:0] i_skew_high;
	logic [7:0] q_skew_low;
	logic [7:0] q_skew_high;
	logic [7:0] i_dc_low;
	logic [7:0] i_dc_high;
	logic [7:0] q_dc_low;
	logic [7:0] q_dc_high;
	logic [7:0] i_fullscale_low;
	logic [7:0] i_control;
	logic tuning_apply_request;
	logic tuning_apply_done;
	logic frame_reset_request;
	logic frame_reset_done;
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	logic frame_meta;
	logic frame_sync;
	logic [7:0] frame_run;
	logic frame_armed_seen;
	dccr_pkg::dccr_frame_t frame_state;
	logic [7:0] next_rdata;
	logic apply_event;
	logic frame_event;
	logic wr_update;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = reg_write && (addr == target);
	endfunction

	assign wr_update = hit(reg_addr, dccr_pkg::ADDR_UPDATE);
	// rising edge of the request bit, taken at the write itself
	assign apply_event = wr_update && reg_wdata[dccr_pkg::BIT_APPLY_REQUEST]
		&& !tuning_apply_request;

	// plain read/write storage
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			hb_control <= dccr_pkg::RESET_ZERO;
			for (int i = 0; i < 4; i++) begin
				tuning_pending[i] <= dccr_pkg::RESET_ZERO;
			end
			phase_low <= dccr_pkg::RESET_ZERO;
			phase_high <= dccr_pkg::RESET_ZERO;
			i_skew_low <= dccr_pkg::RESET_ZERO;
			i_skew_high <= dccr_pkg::RESET_ZERO;
			q_skew_low <= dccr_pkg::RESET_ZERO;
			q_skew_high <= dccr_pkg::RESET_ZERO;
			i_dc_low <= dccr_pkg::RESET_ZERO;
			i_dc_high <= dccr_pkg::RESET_ZERO;
			q_dc_low <= dccr_pkg::RESET_ZERO;
			q_dc_high <= dccr_pkg::RESET_ZERO;
			i_fullscale_low <= dccr_pkg::RESET_I_FULLSCALE_LOW;
			i_control <= dccr_pkg::RESET_I_CONTROL;
		end else if (clk_en && reg_write) begin
			case (reg_addr)
				dccr_pkg::ADDR_HB_CONTROL: hb_control <= reg_wdata;
				// pending bytes only; the oscillator sees them on apply
				dccr_pkg::ADDR_TUNING_BYTE0: tuning_pending[0] <= reg_wdata;
				dccr_pkg::ADDR_TUNING_BYTE1: tuning_pending[1] <= reg_wdata;
				dccr_pkg::ADDR_TUNING_BYTE2: tuning_pending[2] <= reg_wdata;
				dccr_pkg::ADDR_TUNING_BYTE3: tuning_pending[3] <= reg_wdata;
				dccr_pkg::ADDR_PHASE_LOW: phase_low <= reg_wdata;
				dccr_pkg::ADDR_PHASE_HIGH: phase_high <= reg_wdata;
				dccr_pkg::ADDR_I_SKEW_LOW: i_skew_low <= reg_wdata;
				dccr_pkg::ADDR_I_SKEW_HIGH: i_skew_high <= reg_wdata & dccr_pkg::SKEW_HIGH_MASK;
				dccr_pkg::ADDR_Q_SKEW_LOW: q_skew_low <= reg_wdata;
				dccr_pkg::ADDR_Q_SKEW_HIGH: q_skew_high <= reg_wdata & dccr_pkg::SKEW_HIGH_MASK;
				dccr_pkg::ADDR_I_DC_LOW: i_dc_low <= reg_wdata;
				dccr_pkg::ADDR_I_DC_HIGH: i_dc_high <= reg_wdata;
				dccr_pkg::ADDR_Q_DC_LOW: q_dc_low <= reg_wdata;
				dccr_pkg::ADDR_Q_DC_HIGH: q_dc_high <= reg_wdata;
				dccr_pkg::ADDR_I_FULLSCALE_LOW: i_fullscale_low <= reg_wdata;
				dccr_pkg::ADDR_I_CONTROL: i_control <= reg_wdata & dccr_pkg::CONTROL_MASK;
				default: ;
			endcase
		end
	end

	// tuning word apply handshake
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			tuning_apply_request <= 1'b0;
			tuning_apply_done <= 1'b0;
			carrier_tuning_word <= '0;
		end else if (clk_en) begin
			if (wr_update) begin
				tuning_apply_request <= reg_wdata[dccr_pkg::BIT_APPLY_REQUEST];
			end
			if (apply_event) begin
				carrier_tuning_word <= {tuning_pending[3], tuning_pending[2],
					tuning_pending[1], tuning_pending[0]};
				tuning_apply_done <= 1'b1;
			end else if (wr_update && !reg_wdata[dccr_pkg::BIT_APPLY_REQUEST]) begin
				tuning_apply_done <= 1'b0;
			end
		end
	end

	// frame pin is asynchronous: two flops before use
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			frame_meta <= 1'b0;
			frame_sync <= 1'b0;
		end else if (clk_en) begin
			frame_meta <= frame_pin;
			frame_sync <= frame_meta;
		end
	end

	// an extended pulse is one held high for FRAME_EXT_CYCLES synchronised cycles
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			frame_run <= 8'h00;
		end else if (clk_en) begin
			if (!frame_sync) begin
				frame_run <= 8'h00;
			end else if (frame_run != 8'hff) begin
				frame_run <= frame_run + 8'h01;
			end
		end
	end

	assign frame_event = frame_sync && (frame_run == 8'(FRAME_EXT_CYCLES - 1));

	// frame reset handshake; a pulse already high when armed is not counted
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			frame_state <= dccr_pkg::DCCR_FRAME_IDLE;
			frame_reset_request <= 1'b0;
			frame_reset_done <= 1'b0;
			frame_armed_seen <= 1'b0;
			carrier_phase_load <= 1'b0;
			carrier_phase_start <= '0;
		end else if (clk_en) begin
			carrier_phase_load <= 1'b0;
			if (wr_update) begin
				frame_reset_request <= reg_wdata[dccr_pkg::BIT_FRAME_REQUEST];
			end
			case (frame_state)
				dccr_pkg::DCCR_FRAME_IDLE: begin
					frame_armed_seen <= 1'b0;
					if (wr_update && reg_wdata[dccr_pkg::BIT_FRAME_REQUEST]
						&& !frame_reset_request) begin
						frame_state <= dccr_pkg::DCCR_FRAME_ARMED;
						frame_reset_done <= 1'b0;
					end else if (wr_update && !reg_wdata[dccr_pkg::BIT_FRAME_REQUEST]) begin
						frame_reset_done <= 1'b0;
					end
				end
				dccr_pkg::DCCR_FRAME_ARMED: begin
					if (!frame_sync) begin
						frame_armed_seen <= 1'b1;
					end
					if (wr_update && !reg_wdata[dccr_pkg::BIT_FRAME_REQUEST]) begin
						frame_state <= dccr_pkg::DCCR_FRAME_IDLE;
					end else if (frame_event && frame_armed_seen) begin
						carrier_phase_load <= 1'b1;
						carrier_phase_start <= {phase_high, phase_low};
						frame_reset_done <= 1'b1;
						frame_state <= dccr_pkg::DCCR_FRAME_DONE;
					end
				end
				dccr_pkg::DCCR_FRAME_DONE: begin
					if (wr_update && !reg_wdata[dccr_pkg::BIT_FRAME_REQUEST]) begin
						frame_reset_done <= 1'b0;
						frame_state <= dccr_pkg::DCCR_FRAME_IDLE;
					end
				end
				default: frame_state <= dccr_pkg::DCCR_FRAME_IDLE;
			endcase
		end
	end

	// interrupt status: set wins over a same-cycle clear
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			irq_status <= dccr_pkg::IRQ_NONE;
			irq_enable <= dccr_pkg::IRQ_NONE;
			irq <= 1'b0;
		end else if (clk_en) begin
			if (hit(reg_addr, dccr_pkg::ADDR_IRQ_ENABLE)) begin
				irq_enable <= reg_wdata[1:0];
			end
			irq_status <= (irq_status & ~(hit(reg_addr, dccr_pkg::ADDR_IRQ_CLEAR)
				? reg_wdata[1:0] : 2'h0)) | {carrier_phase_load, apply_event};
			irq <= |(irq_status & irq_enable);
		end
	end

	// steered outputs
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			third_halfband_bypass <= 1'b0;
			inphase_skew <= '0;
			quadrature_skew <= '0;
			inphase_sleep <= 1'b0;
			inphase_fullscale_code <= {dccr_pkg::RESET_I_CONTROL[1:0],
				dccr_pkg::RESET_I_FULLSCALE_LOW};
		end else if (clk_en) begin
			third_halfband_bypass <= hb_control[dccr_pkg::BIT_STAGE3_BYPASS];
			inphase_skew <= {i_skew_high[1:0], i_skew_low};
			quadrature_skew <= {q_skew_high[1:0], q_skew_low};
			inphase_sleep <= i_control[dccr_pkg::BIT_I_SLEEP];
			inphase_fullscale_code <= {i_control[1:0], i_fullscale_low};
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			dccr_pkg::ADDR_HB_CONTROL: next_rdata = hb_control;
			dccr_pkg::ADDR_CHIP_IDENTITY: next_rdata = CHIP_IDENTITY;
			dccr_pkg::ADDR_TUNING_BYTE0: next_rdata = tuning_pending[0];
			dccr_pkg::ADDR_TUNING_BYTE1: next_rdata = tuning_pending[1];
			dccr_pkg::ADDR_TUNING_BYTE2: next_rdata = tuning_pending[2];
			dccr_pkg::ADDR_TUNING_BYTE3: next_rdata = tuning_pending[3];
			dccr_pkg::ADDR_PHASE_LOW: next_rdata = phase_low;
			dccr_pkg::ADDR_PHASE_HIGH: next_rdata = phase_high;
			dccr_pkg::ADDR_UPDATE: begin
				next_rdata[dccr_pkg::BIT_APPLY_REQUEST] = tuning_apply_request;
				next_rdata[dccr_pkg::BIT_APPLY_DONE] = tuning_apply_done;
				next_rdata[dccr_pkg::BIT_FRAME_REQUEST] = frame_reset_request;
				next_rdata[dccr_pkg::BIT_FRAME_DONE] = frame_reset_done;
			end
			dccr_pkg::ADDR_I_SKEW_LOW: next_rdata = i_skew_low;
			dccr_pkg::ADDR_I_SKEW_HIGH: next_rdata = i_skew_high;
			dccr_pkg::ADDR_Q_SKEW_LOW: next_rdata = q_skew_low;
			dccr_pkg::ADDR_Q_SKEW_HIGH: next_rdata = q_skew_high;
			dccr_pkg::ADDR_I_DC_LOW: next_rdata = i_dc_low;
			dccr_pkg::ADDR_I_DC_HIGH: next_rdata = i_dc_high;
			dccr_pkg::ADDR_Q_DC_LOW: next_rdata = q_dc_low;
			dccr_pkg::ADDR_Q_DC_HIGH: next_rdata = q_dc_high;
			dccr_pkg::ADDR_I_FULLSCALE_LOW: next_rdata = i_fullscale_low;
			dccr_pkg::ADDR_I_CONTROL: next_rdata = i_control;
			dccr_pkg::ADDR_IRQ_STATUS: next_rdata = {6'h00, irq_status};
			dccr_pkg::ADDR_IRQ_ENABLE: next_rdata = {6'h00, irq_enable};
			default: next_rdata = 8'h00;
		endcase
	end

	// read data stands one cycle only, zero otherwise
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			reg_rdata <= reg_read ? next_rdata : 8'h00;
		end
	end

	dccr_sample_adjust #(.WIDTH(SAMPLE_WIDTH)) u_inphase_adjust (
		.ref_clk(ref_clk),
		.reset(reset),
		.clk_en(clk_en),
		.sample_in(inphase_sample),
		.dc_shift({i_dc_high, i_dc_low}),
		.sample_out(inphase_out)
	);

	dccr_sample_adjust #(.WIDTH(SAMPLE_WIDTH)) u_quadrature_adjust (
		.ref_clk(ref_clk),
		.reset(reset),
		.clk_en(clk_en),
		.sample_in(quadrature_sample),
		.dc_shift({q_dc_high, q_dc_low}),
		.sample_out(quadrature_out)
	);
endmodule

// [verif/dccr_regs_assertions.sv]
// dccr_regs_assertions: port-level checks of the carrier correction slice
// assumes clk_en high whenever software uses the strobe port
`timescale 1ns/1ps
module dccr_regs_assertions #(
	parameter int SAMPLE_WIDTH = 16,
	parameter int FRAME_EXT_CYCLES = 2,
	parameter logic [7:0] CHIP_IDENTITY = 8'h5a // arbitrary value
) (
	input wire logic ref_clk, // data clock
	input wire logic reset, // async, active high
	input wire logic clk_en, // run enable
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_write, // write strobe
	input wire logic reg_read, // read strobe
	input wire logic [7:0] reg_rdata, // read data
	input wire logic third_halfband_bypass, // bypass output
	input wire logic [31:0] carrier_tuning_word, // active word
	input wire logic carrier_phase_load, // oscillator reset pulse
	input wire logic [15:0] carrier_phase_start, // start phase
	input wire logic [9:0] inphase_skew, // in-phase skew
	input wire logic inphase_sleep, // in-phase sleep
	input wire logic [9:0] inphase_fullscale_code // full-scale code
);
	logic req_bit;
	logic [31:0] pend;
	logic [15:0] ph;
	// shadows of what software wrote, to judge what the design loads
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			req_bit <= 1'b0;
			pend <= '0;
			ph <= '0;
		end else if (reg_write && clk_en) begin
			if (reg_addr == dccr_pkg::ADDR_UPDATE) req_bit <= reg_wdata[0];
			if (reg_addr[7:2] == 6'h0c) pend[reg_addr[1:0]*8 +: 8] <= reg_wdata;
			if (reg_addr == dccr_pkg::ADDR_PHASE_LOW) ph[7:0] <= reg_wdata;
			if (reg_addr == dccr_pkg::ADDR_PHASE_HIGH) ph[15:8] <= reg_wdata;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_wr(a);
		reg_write && clk_en && reg_addr == a;
	endsequence
	sequence s_rd(a);
		reg_read && clk_en && reg_addr == a;
	endsequence
	sequence s_apply;
		s_wr(dccr_pkg::ADDR_UPDATE) ##0 (reg_wdata[0] && !req_bit);
	endsequence
	property p_ident;
		s_rd(dccr_pkg::ADDR_CHIP_IDENTITY) |=> reg_rdata == CHIP_IDENTITY;
	endproperty
	a_ident: assert property (p_ident) else $error("identity read wrong");
	property p_word_hold;
		$changed(carrier_tuning_word) |-> $past(reg_write && reg_addr == dccr_pkg::ADDR_UPDATE
			&& reg_wdata[0] && !req_bit);
	endproperty
	a_word_hold: assert property (p_word_hold) else $error("word changed unasked");
	property p_apply;
		s_apply |=> carrier_tuning_word == $past(pend);
	endproperty
	a_apply: assert property (p_apply) else $error("pending word not loaded");
	property p_done;
		s_apply ##[1:2] s_rd(dccr_pkg::ADDR_UPDATE) |=> reg_rdata[dccr_pkg::BIT_APPLY_DONE];
	endproperty
	a_done: assert property (p_done) else $error("apply done flag missing");
	property p_load_pulse;
		carrier_phase_load |=> !carrier_phase_load;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("reset pulse too long");
	property p_start;
		carrier_phase_load |-> carrier_phase_start == ph;
	endproperty
	a_start: assert property (p_start) else $error("start phase wrong");
	property p_bypass;
		s_wr(dccr_pkg::ADDR_HB_CONTROL) |-> ##2 third_halfband_bypass == $past(reg_wdata[0], 2);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not steered");
	property p_skew;
		s_wr(dccr_pkg::ADDR_I_SKEW_LOW) |-> ##2 inphase_skew[7:0] == $past(reg_wdata, 2);
	endproperty
	a_skew: assert property (p_skew) else $error("skew not steered");
	property p_sleep;
		s_wr(dccr_pkg::ADDR_I_CONTROL) |-> ##2 inphase_sleep == $past(reg_wdata[7], 2);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not steered");
	property p_fs;
		s_wr(dccr_pkg::ADDR_I_FULLSCALE_LOW) |-> ##2 inphase_fullscale_code[7:0] == $past(reg_wdata, 2);
	endproperty
	a_fs: assert property (p_fs) else $error("full-scale not steered");
endmodule

bind dccr_regs dccr_regs_assertions #(.SAMPLE_WIDTH(SAMPLE_WIDTH),
	.FRAME_EXT_CYCLES(FRAME_EXT_CYCLES), .CHIP_IDENTITY(CHIP_IDENTITY)) u_chk (.ref_clk, .reset,
	.clk_en, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .third_halfband_bypass,
	.carrier_tuning_word, .carrier_phase_load, .carrier_phase_start, .inphase_skew,
	.inphase_sleep, .inphase_fullscale_code);

// [verif/dccr_regs_tb.sv]
// dccr_regs_tb: directed register and datapath tests of dccr_regs
// assumes a 25 MHz clock and the one-cycle strobe port of the design
`timescale 1ns/1ps
module dccr_regs_tb;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic frame_pin = 1'b0;
	logic [15:0] inphase_sample = 16'h0000;
	logic [15:0] quadrature_sample = 16'h0000;
	logic [7:0] reg_rdata;
	logic [15:0] inphase_out, quadrature_out, carrier_phase_start;
	logic third_halfband_bypass, carrier_phase_load, inphase_sleep, irq;
	logic [31:0] carrier_tuning_word;
	logic [9:0] inphase_skew, quadrature_skew, inphase_fullscale_code;
	logic [7:0] ta [7] = '{8'h1e, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h40, 8'h41};
	logic [7:0] td [7] = '{8'h01, 8'h55, 8'hff, 8'haa, 8'h02, 8'h3c, 8'h82};
	int failures = 0;
	int checks = 0;
	int loads = 0;
	int i;
	dccr_regs #(.FRAME_EXT_CYCLES(2)) uut (.ref_clk, .reset, .clk_en, .reg_addr, .reg_wdata,
		.reg_write, .reg_read, .reg_rdata, .frame_pin, .inphase_sample, .quadrature_sample,
		.inphase_out, .quadrature_out, .third_halfband_bypass, .carrier_tuning_word,
		.carrier_phase_load, .carrier_phase_start, .inphase_skew, .quadrature_skew,
		.inphase_sleep, .inphase_fullscale_code, .irq);
	initial forever #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (carrier_phase_load === 1'b1) loads <= loads + 1;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		chk(inphase_fullscale_code, 10'h1f9);
		rd(8'h1f, dccr_pkg::IDENTITY_DEFAULT);
		wr(8'h1f, 8'h00);
		rd(8'h1f, dccr_pkg::IDENTITY_DEFAULT);
		rd(8'h40, 8'hf9);
		rd(8'h41, 8'h01);
		wr(8'h37, 8'hff);
		rd(8'h37, 8'h00);
		for (i = 0; i < 4; i++) wr(8'(8'h30 + i), 8'(32'h89abcdef >> (i * 8)));
		for (i = 0; i < 4; i++) rd(8'(8'h30 + i), 8'(32'h89abcdef >> (i * 8)));
		chk(carrier_tuning_word, 32'h0);
		wr(8'h51, 8'h03);
		wr(8'h36, 8'h01);
		rd(8'h36, 8'h03);
		chk(carrier_tuning_word, 32'h89abcdef);
		chk(irq, 1'b1);
		rd(8'h50, 8'h01);
		wr(8'h52, 8'h01);
		cyc(2);
		chk(irq, 1'b0);
		// rewriting one without a zero first must not reload
		wr(8'h30, 8'h11);
		wr(8'h36, 8'h01);
		cyc(2);
		chk(carrier_tuning_word, 32'h89abcdef);
		wr(8'h36, 8'h00);
		rd(8'h36, 8'h00);
		wr(8'h36, 8'h01);
		cyc(2);
		chk(carrier_tuning_word, 32'h89abcd11);
		wr(8'h36, 8'h00);
		wr(8'h52, 8'h03);
		wr(8'h34, 8'h34);
		wr(8'h35, 8'h92);
		wr(8'h36, 8'h10);
		rd(8'h36, 8'h10);
		@(posedge ref_clk) frame_pin <= 1'b1;
		@(posedge ref_clk) frame_pin <= 1'b0;
		cyc(8);
		chk(loads, 0);
		@(posedge ref_clk) frame_pin <= 1'b1;
		for (i = 0; i < 20 && loads == 0; i++) cyc(1);
		@(posedge ref_clk) frame_pin <= 1'b0;
		if (loads == 0) begin
			failures++;
			print_verdict;
		end
		cyc(4);
		chk(loads, 1);
		chk(carrier_phase_start, 16'h9234);
		rd(8'h36, 8'h30);
		chk(irq, 1'b1);
		wr(8'h51, 8'h00);
		cyc(2);
		chk(irq, 1'b0);
		rd(8'h50, 8'h02);
		wr(8'h36, 8'h00);
		rd(8'h36, 8'h00);
		// acknowledge bits must ignore software writes
		wr(8'h36, 8'h22);
		rd(8'h36, 8'h00);
		for (i = 0; i < 7; i++) wr(ta[i], td[i]);
		cyc(2);
		chk(third_halfband_bypass, 1'b1);
		chk(inphase_skew, 10'h355);
		chk(quadrature_skew, 10'h2aa);
		chk(inphase_sleep, 1'b1);
		chk(inphase_fullscale_code, 10'h23c);
		rd(8'h39, 8'h03);
		rd(8'h41, 8'h82);
		// a write while the enable is low must be lost
		@(posedge ref_clk) clk_en <= 1'b0;
		wr(8'h38, 8'h00);
		@(posedge ref_clk) clk_en <= 1'b1;
		rd(8'h38, 8'h55);
		chk(inphase_skew, 10'h355);
		wr(8'h3c, 8'h10);
		wr(8'h3d, 8'h00);
		wr(8'h3e, 8'hff);
		wr(8'h3f, 8'hff);
		@(posedge ref_clk);
		inphase_sample <= 16'h0100;
		quadrature_sample <= 16'h0005;
		cyc(2);
		chk(inphase_out, 16'h0110);
		chk(quadrature_out, 16'h0004);
		@(posedge ref_clk) inphase_sample <= 16'h7ff8;
		cyc(2);
		chk(inphase_out, 16'h7fff);
		print_verdict;
	end
endmodule
